// ===== hw/spims_params.svh
// Purpose: Constants for the SPI master/slave port.
// Assumes: Byte-wide I/O bus with separate read and write strobes.
// Notes:   Rule summary follows.
// Operation
// - Four modes; shift and sample on opposite edges
// - Polarity one: SCK idles high
// - Phase picks sample edge: leading or trailing
// - No serial activity unless port enabled
// - Bit order one sends LSB first
// - Master select one: master, zero: slave
// - Master with low slave select input drops mastership
// - Interrupt when done flag, enable, global enable
// - Master SCK divisors 4,16,64,128 or 2,8,32,64
// - Rate select ignored in slave operation
// - Done flag set after each byte
// - Done flag cleared on vector entry
// - Status read then data access clears done
// - Data write during transfer sets collision
// - Collision read then data access clears both
// - Double rate halves SCK period
// - Data write loads shifter and starts
// - Data read returns received byte buffer
// - Master stops SCK after eight bits
// - Receive double buffered; unread byte overwritten
// - Slave select high resets slave shifting
`ifndef SPIMS_PARAMS_SVH
`define SPIMS_PARAMS_SVH

`define SPIMS_ADDR_CTRL   8'h4c
`define SPIMS_ADDR_STAT   8'h4d
`define SPIMS_ADDR_DATA   8'h4e

`define SPIMS_CTRL_IRQEN  7
`define SPIMS_CTRL_EN     6
`define SPIMS_CTRL_ORDER  5
`define SPIMS_CTRL_MASTER_SELECT_BIT   4
`define SPIMS_CTRL_CLOCK_POLARITY_BIT   3
`define SPIMS_CTRL_CLOCK_PHASE_BIT   2
`define SPIMS_CTRL_RATEHI 1
`define SPIMS_CTRL_RATELO 0
`define SPIMS_STAT_DONE   7
`define SPIMS_STAT_WRITE_COLLISION_FLAG_BIT   6
`define SPIMS_STAT_DBL    0

`define SPIMS_RESET_BYTE  8'h00
`define SPIMS_LAST_EDGE   4'hf

// Half SCK period in core clocks, minus one
`define SPIMS_HALF_DIV2   7'h00
`define SPIMS_HALF_DIV4   7'h01
`define SPIMS_HALF_DIV8   7'h03
`define SPIMS_HALF_DIV16  7'h07
`define SPIMS_HALF_DIV32  7'h0f
`define SPIMS_HALF_DIV64  7'h1f
`define SPIMS_HALF_DIV128 7'h3f

`endif

// ===== hw/spims_pkg.sv
// Purpose: Types for the SPI master/slave port.
// Assumes: Nothing beyond the constants header.
// Notes:   Shared by the port and its receive buffer.
package spims_pkg;
    typedef logic [7:0] spims_byte_t;
    typedef enum logic [1:0] {
        SPIMS_IDLE,
        SPIMS_WAIT,
        SPIMS_SHIFT
    } spims_state_t;
endpackage : spims_pkg

// ===== hw/spims_rx_buf.sv
// Purpose: Two-entry buffer for received bytes.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Push and pop may happen in the same cycle.
`include "spims_params.svh"
module spims_rx_buf import spims_pkg::*; (
    // Clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_nrst,
    // Fill side
    input  wire logic  i_in_valid,
    input  spims_byte_t i_in_data,
    output logic       o_in_ready,
    // Drain side
    output logic       o_out_valid,
    output spims_byte_t o_out_data,
    input  wire logic  i_out_ready
);
    spims_byte_t mem [2];
    logic [1:0]  count;
    logic        rd_ptr;
    logic        wr_ptr;
    logic        push;
    logic        pop;

    assign o_in_ready  = (count != 2'h2);
    assign o_out_valid = (count != 2'h0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            count  <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            mem[0] <= `SPIMS_RESET_BYTE;
            mem[1] <= `SPIMS_RESET_BYTE;
        end else if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule : spims_rx_buf

// ===== hw/spims_port.sv
// Purpose: SPI port, master or slave, with control, status and data registers.
// Assumes: All pins synchronous to i_core_clk; external SCK slow enough.
// Notes:   Register reads answer one cycle after the strobe.
`include "spims_params.svh"
module spims_port import spims_pkg::*; (
    // Clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_nrst,
    // I/O register bus
    input  wire logic [7:0] i_io_addr,
    input  wire logic  i_io_wr,
    input  wire logic  i_io_rd,
    input  spims_byte_t i_io_wdata,
    output spims_byte_t o_io_rdata,
    // Interrupt handshake
    input  wire logic  i_global_ie,
    input  wire logic  i_vector_ack,
    output logic       o_irq,
    // Serial pins
    input  wire logic  i_ss_is_input,
    input  wire logic  i_ss_n,
    input  wire logic  i_sck,
    output logic       o_sck,
    output logic       o_sck_oe,
    input  wire logic  i_mosi,
    output logic       o_mosi,
    output logic       o_mosi_oe,
    input  wire logic  i_miso,
    output logic       o_miso,
    output logic       o_miso_oe,
    // Received byte stream
    output logic       o_rx_valid,
    output spims_byte_t o_rx_data,
    input  wire logic  i_rx_ready
);
    spims_byte_t  control_reg;
    logic         double_rate;
    logic         transfer_done_flag;
    logic         write_collision_flag;
    logic         clr_armed;
    spims_byte_t  rx_hold;
    spims_byte_t  tx_sh;
    spims_byte_t  rx_sh;
    spims_byte_t  next_rx;
    logic [3:0]   edge_cnt;
    logic [6:0]   div_cnt;
    logic [6:0]   half_lim;
    logic         sck_lvl;
    logic         sck_prev;
    spims_state_t state;
    spims_state_t next_state;
    logic         buf_ready;

    wire port_enable    = control_reg[`SPIMS_CTRL_EN];
    wire master_select  = control_reg[`SPIMS_CTRL_MASTER_SELECT_BIT];
    wire bit_order      = control_reg[`SPIMS_CTRL_ORDER];
    wire clock_polarity = control_reg[`SPIMS_CTRL_CLOCK_POLARITY_BIT];
    wire clock_phase    = control_reg[`SPIMS_CTRL_CLOCK_PHASE_BIT];
    wire [1:0] rate_sel = {control_reg[`SPIMS_CTRL_RATEHI], control_reg[`SPIMS_CTRL_RATELO]};

    wire wr_ctrl  = i_io_wr && (i_io_addr == `SPIMS_ADDR_CTRL);
    wire wr_stat  = i_io_wr && (i_io_addr == `SPIMS_ADDR_STAT);
    wire wr_data  = i_io_wr && (i_io_addr == `SPIMS_ADDR_DATA);
    wire rd_stat  = i_io_rd && (i_io_addr == `SPIMS_ADDR_STAT);
    wire rd_data  = i_io_rd && (i_io_addr == `SPIMS_ADDR_DATA);
    wire data_acc = wr_data || rd_data;

    // Another master pulled our select low while we were master
    wire mode_fault = port_enable && master_select && i_ss_is_input && !i_ss_n;
    wire slave_act  = port_enable && !master_select && !i_ss_n;
    wire hold_idle  = !port_enable || mode_fault || (!master_select && i_ss_n);
    wire busy       = (state != SPIMS_IDLE) || (edge_cnt != 4'h0);

    // Rate select only feeds the master divider, so a slave ignores it
    always_comb begin
        unique case ({double_rate, rate_sel})
            3'b000: half_lim = `SPIMS_HALF_DIV4;
            3'b001: half_lim = `SPIMS_HALF_DIV16;
            3'b010: half_lim = `SPIMS_HALF_DIV64;
            3'b011: half_lim = `SPIMS_HALF_DIV128;
            3'b100: half_lim = `SPIMS_HALF_DIV2;
            3'b101: half_lim = `SPIMS_HALF_DIV8;
            3'b110: half_lim = `SPIMS_HALF_DIV32;
            3'b111: half_lim = `SPIMS_HALF_DIV64;
        endcase
    end

    wire tick      = (state == SPIMS_SHIFT) && master_select && (div_cnt == half_lim);
    wire sck_chg   = slave_act && (i_sck != sck_prev);
    wire ev        = master_select ? tick : sck_chg;
    wire lead      = master_select ? !sck_lvl : (i_sck != clock_polarity);
    wire serial_in = master_select ? i_miso : i_mosi;
    // Sample and setup always fall on opposite edges
    wire sample_ev = ev && (lead ^ clock_phase);
    wire setup_ev  = ev && !(lead ^ clock_phase) && !(clock_phase && edge_cnt == 4'h0);
    wire byte_done = ev && (edge_cnt == `SPIMS_LAST_EDGE);

    always_comb begin
        next_rx = rx_sh;
        if (sample_ev) begin
            next_rx = bit_order ? {serial_in, rx_sh[7:1]} : {rx_sh[6:0], serial_in};
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            SPIMS_IDLE: begin
                if (master_select && wr_data) begin
                    next_state = SPIMS_WAIT;
                end else if (!master_select && ev) begin
                    next_state = SPIMS_SHIFT;
                end
            end
            // Hold off a master byte while the stream buffer is full
            SPIMS_WAIT: begin
                if (buf_ready) begin
                    next_state = SPIMS_SHIFT;
                end
            end
            SPIMS_SHIFT: begin
                if (byte_done) begin
                    next_state = SPIMS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || hold_idle) begin
            state <= SPIMS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || hold_idle) begin
            div_cnt <= 7'h00;
        end else if (state != SPIMS_SHIFT || tick) begin
            div_cnt <= 7'h00;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    // Partial byte is dropped when the select rises
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || hold_idle) begin
            edge_cnt <= 4'h0;
            sck_lvl  <= 1'b0;
        end else begin
            if (ev) begin
                edge_cnt <= edge_cnt + 4'h1;
            end
            if (tick) begin
                sck_lvl <= ~sck_lvl;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= i_sck;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            tx_sh <= `SPIMS_RESET_BYTE;
            rx_sh <= `SPIMS_RESET_BYTE;
        end else begin
            if (wr_data && !busy) begin
                tx_sh <= i_io_wdata;
            end else if (setup_ev && !hold_idle) begin
                tx_sh <= bit_order ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
            end
            if (!hold_idle) begin
                rx_sh <= next_rx;
            end
        end
    end

    // Last completed byte overwrites an unread one
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rx_hold <= `SPIMS_RESET_BYTE;
        end else if (byte_done && !hold_idle) begin
            rx_hold <= next_rx;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            control_reg <= `SPIMS_RESET_BYTE;
        end else begin
            if (wr_ctrl) begin
                control_reg <= i_io_wdata;
            end
            if (mode_fault) begin
                control_reg[`SPIMS_CTRL_MASTER_SELECT_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            double_rate <= 1'b0;
        end else if (wr_stat) begin
            double_rate <= i_io_wdata[`SPIMS_STAT_DBL];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            clr_armed <= 1'b0;
        end else if (data_acc) begin
            clr_armed <= 1'b0;
        end else if (rd_stat && (transfer_done_flag || write_collision_flag)) begin
            clr_armed <= 1'b1;
        end
    end

    // Setting wins over a clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            transfer_done_flag <= 1'b0;
        end else if ((byte_done && !hold_idle) || mode_fault) begin
            transfer_done_flag <= 1'b1;
        end else if (i_vector_ack || (clr_armed && data_acc)) begin
            transfer_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            write_collision_flag <= 1'b0;
        end else if (wr_data && busy) begin
            write_collision_flag <= 1'b1;
        end else if (clr_armed && data_acc) begin
            write_collision_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_io_rdata <= `SPIMS_RESET_BYTE;
        end else if (i_io_rd) begin
            unique case (i_io_addr)
                `SPIMS_ADDR_CTRL: o_io_rdata <= control_reg;
                `SPIMS_ADDR_STAT: o_io_rdata <= {transfer_done_flag, write_collision_flag,
                                                 5'h00, double_rate};
                `SPIMS_ADDR_DATA: o_io_rdata <= rx_hold;
                default:          o_io_rdata <= `SPIMS_RESET_BYTE;
            endcase
        end
    end

    spims_rx_buf u_rx_buf (
        .i_core_clk  (i_core_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (byte_done && !hold_idle),
        .i_in_data   (next_rx),
        .o_in_ready  (buf_ready),
        .o_out_valid (o_rx_valid),
        .o_out_data  (o_rx_data),
        .i_out_ready (i_rx_ready)
    );

    assign o_irq     = transfer_done_flag && control_reg[`SPIMS_CTRL_IRQEN] && i_global_ie;
    assign o_sck     = sck_lvl ^ clock_polarity;
    assign o_sck_oe  = port_enable && master_select;
    assign o_mosi    = bit_order ? tx_sh[0] : tx_sh[7];
    assign o_mosi_oe = port_enable && master_select;
    assign o_miso    = bit_order ? tx_sh[0] : tx_sh[7];
    assign o_miso_oe = slave_act;

    irq_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(transfer_done_flag) && control_reg[`SPIMS_CTRL_IRQEN] && i_global_ie |-> o_irq)
        else $error("irq not raised on done flag");
    master_select_bit_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        mode_fault |=> !master_select && transfer_done_flag && state == SPIMS_IDLE)
        else $error("mode fault not handled");
    enable_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !port_enable |-> !o_sck_oe ##1 (state == SPIMS_IDLE && edge_cnt == 4'h0))
        else $error("disabled port not idle");
    sck_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        state != SPIMS_SHIFT |-> o_sck == clock_polarity)
        else $error("sck not at idle level");
    write_collision_flag_bit_set_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_data && busy |=> write_collision_flag && ($past(setup_ev) || $stable(tx_sh)))
        else $error("collision not flagged");
    transfer_done_flag_bit_done_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        byte_done && !hold_idle |=> transfer_done_flag && rx_hold == $past(next_rx))
        else $error("byte completion not flagged");
    rate_div_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        tick && !byte_done && $stable(control_reg) && {double_rate, rate_sel} == 3'b000
        |=> !tick ##1 tick)
        else $error("div4 sck spacing wrong");
    dbl_rate_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        tick && !byte_done && {double_rate, rate_sel} == 3'b100 && !hold_idle |=> tick)
        else $error("div2 sck spacing wrong");
    slave_ss_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        port_enable && !master_select && i_ss_n |-> !o_miso_oe ##1 edge_cnt == 4'h0)
        else $error("slave not reset by select");
    vector_clr_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_vector_ack && !byte_done && !mode_fault |=> !transfer_done_flag)
        else $error("vector entry did not clear flag");
    flag_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        rd_stat && write_collision_flag ##1 !data_acc
        ##1 (rd_data && !wr_data && !byte_done && !mode_fault)
        |=> !write_collision_flag && !transfer_done_flag)
        else $error("flags not cleared by access");
    order_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_data && !busy && !wr_ctrl |=> o_mosi == (bit_order ? $past(i_io_wdata[0])
                                                    : $past(i_io_wdata[7])))
        else $error("first bit order wrong");
    read_data_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        rd_data |=> o_io_rdata == $past(rx_hold))
        else $error("data read not from buffer");
endmodule : spims_port

// ===== verification/spims_far_slave.sv
// Purpose: Far-side SPI slave for master-mode runs.
// Assumes: Select comes from the bench; mode inputs steady per frame.
// Notes:   Reacts to SCK changes at once, like a real pin.
module spims_far_slave (
    // Serial pins
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    output logic            o_miso,
    // Frame setup
    input  wire logic       i_clock_polarity_bit,
    input  wire logic       i_clock_phase_bit,
    input  wire logic       i_lsb,
    input  wire logic [7:0] i_tx,
    output logic [7:0]      o_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int ti = 0;
    int ri = 0;

    function automatic logic pick(int k);
        return i_lsb ? i_tx[k] : i_tx[7 - k];
    endfunction : pick

    initial o_miso = 1'b0;
    initial o_rx = 8'h00;
    // Sampling on the leading edge needs the first bit out early
    always @(negedge i_ss_n) begin
        ri = 0;
        ti = i_clock_phase_bit ? 0 : 1;
        o_miso = pick(0);
    end
    // Released line must not hold its last bit
    always @(posedge i_ss_n) o_miso = ~o_miso;
    always @(i_sck) begin
        if (!i_ss_n) begin
            if ((i_sck != i_clock_polarity_bit) != i_clock_phase_bit) begin
                o_rx[i_lsb ? ri : 7 - ri] = i_mosi;
                ri++;
            end else if (ti < 8) begin
                o_miso = pick(ti);
                ti++;
            end
        end
    end
endmodule : spims_far_slave

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the SPI master/slave port.
// Assumes: Far-side slave model answers in master runs.
// Notes:   Pin levels resolved here from each side's enable.
`include "spims_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] a_ct = `SPIMS_ADDR_CTRL;
    localparam logic [7:0] a_st = `SPIMS_ADDR_STAT;
    localparam logic [7:0] a_dt = `SPIMS_ADDR_DATA;
    logic       clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rd_s = 1'b0, gie = 1'b1;
    logic       vack = 1'b0, ss_n = 1'b1, esck = 1'b0, emosi = 1'b0, rxr = 1'b1;
    logic       f_ss_n = 1'b1, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, lsb = 1'b0, ssin = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ftx = 8'h00;
    logic [7:0] rdata, rxd, frx;
    logic       irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, rxv, fmiso;
    logic       sck_w, mosi_w, miso_w;
    int         checked = 0, miscompares = 0;

    assign sck_w = sck_oe ? sck : esck;
    assign mosi_w = mosi_oe ? mosi : emosi;
    assign miso_w = miso_oe ? miso : fmiso;
    always #20 clk = ~clk;

    spims_port DUT (
        .i_core_clk(clk), .i_nrst(nrst), .i_io_addr(addr), .i_io_wr(wr_s),
        .i_io_rd(rd_s), .i_io_wdata(wdata), .o_io_rdata(rdata),
        .i_global_ie(gie), .i_vector_ack(vack), .o_irq(irq),
        .i_ss_is_input(ssin), .i_ss_n(ss_n), .i_sck(sck_w), .o_sck(sck),
        .o_sck_oe(sck_oe), .i_mosi(mosi_w), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
        .i_miso(miso_w), .o_miso(miso), .o_miso_oe(miso_oe),
        .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rxr));
    spims_far_slave FAR (
        .i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(f_ss_n), .o_miso(fmiso),
        .i_clock_polarity_bit(clock_polarity_bit), .i_clock_phase_bit(clock_phase_bit), .i_lsb(lsb), .i_tx(ftx), .o_rx(frx));

    task automatic end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rc(string nm, logic [7:0] a, logic [7:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        #1 chk(nm, e, rdata);
    endtask : rc

    task automatic xfer(logic [7:0] tx, bit ak, output int n);
        f_ss_n <= 1'b0;
        wr(a_dt, tx);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (irq !== 1'b1 && n < 1100);
        if (irq !== 1'b1) begin
            miscompares++;
            $display("[FAIL] done wait expected 1 seen 0");
            end_sim;
        end
        f_ss_n <= 1'b1;
        if (ak) begin
            vack <= 1'b1;
            @(posedge clk);
            vack <= 1'b0;
            #1 chk("irq clear", 8'h00, {7'h00, irq});
        end
    endtask : xfer

    // Mode 0, MSB first; half period of 3 clocks keeps within slave limits
    task automatic sbyte(logic [7:0] m, int tg, output logic [7:0] s);
        for (int t = 0; t < tg; t++) begin
            emosi <= m[7 - t / 2];
            repeat (3) @(posedge clk);
            esck <= ~esck;
            if (t % 2 == 0)
                s = {s[6:0], miso_w};
        end
    endtask : sbyte

    task automatic t_regs;
        rc("ctrl rst", a_ct, 8'h00);
        rc("stat rst", a_st, 8'h00);
        wr(a_ct, 8'h2d);
        wr(a_st, 8'hff);
        wr(8'h4f, 8'hff);
        rc("ctrl rw", a_ct, 8'h2d);
        rc("stat rw", a_st, 8'h01);
        rc("unmapped", 8'h4f, 8'h00);
    endtask : t_regs

    task automatic t_master;
        int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
        int n;
        for (int i = 0; i < 8; i++) begin
            clock_phase_bit = i[0];
            clock_polarity_bit = i[1];
            lsb = i[0] ^ i[2];
            ftx = 8'(8'h35 + i * 29);
            wr(a_st, {7'h00, i[2]});
            wr(a_ct, {2'b11, lsb, 1'b1, clock_polarity_bit, clock_phase_bit, i[1:0]});
            #1 chk("sck idle", {7'h00, clock_polarity_bit}, {7'h00, sck});
            chk("sck oe", 8'h01, {7'h00, sck_oe});
            xfer(~ftx, 1'b1, n);
            checked++;
            if (n != 8 * dv[i]) begin
                miscompares++;
                $display("[FAIL] sck rate expected %0d seen %0d", 8 * dv[i], n);
            end
            chk("far rx", ~ftx, frx);
            rc("rx byte", a_dt, ftx);
        end
    endtask : t_master

    task automatic t_buf;
        logic [7:0] q[$];
        int n;
        {clock_polarity_bit, clock_phase_bit, lsb} = 3'b000;
        rxr <= 1'b0;
        wr(a_ct, 8'hd0);
        for (int k = 0; k < 3; k++) begin
            ftx = 8'(8'ha0 + k);
            if (k < 2)
                xfer(8'h00, 1'b1, n);
        end
        fork
            xfer(8'h00, 1'b1, n);
            begin
                repeat (30) @(posedge clk);
                rxr <= 1'b1;
                #1;
                repeat (80) begin
                    if (rxv === 1'b1 && rxr === 1'b1)
                        q.push_back(rxd);
                    @(posedge clk);
                    #1;
                end
            end
        join
        chk("stall", 8'h01, {7'h00, n > 30});
        for (int k = 0; k < 3; k++)
            chk("stream", 8'(8'ha0 + k), q[k]);
    endtask : t_buf

    task automatic t_coll;
        int n;
        wr(a_st, 8'h00);
        wr(a_ct, 8'hd1);
        ftx = 8'hc3;
        fork
            xfer(8'h5a, 1'b0, n);
            begin
                repeat (10) @(posedge clk);
                wr(a_dt, 8'hff);
            end
        join
        chk("load", 8'h5a, frx);
        rc("coll st", a_st, 8'hc0);
        rc("coll rx", a_dt, 8'hc3);
        rc("cleared", a_st, 8'h00);
    endtask : t_coll

    task automatic t_fault;
        gie <= 1'b0;
        wr(a_ct, 8'hd0);
        // Select as an output must leave mastership alone
        ssin <= 1'b0;
        ss_n <= 1'b0;
        repeat (3) @(posedge clk);
        rc("ss output", a_ct, 8'hd0);
        ssin <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("gated irq", 8'h00, {7'h00, irq});
        gie <= 1'b1;
        ss_n <= 1'b1;
        #1 chk("fault irq", 8'h01, {7'h00, irq});
        rc("fault ctrl", a_ct, 8'hc0);
        chk("fault oe", 8'h00, {7'h00, sck_oe});
        vack <= 1'b1;
        @(posedge clk);
        vack <= 1'b0;
    endtask : t_fault

    task automatic t_off;
        wr(a_ct, 8'h90);
        wr(a_dt, 8'h55);
        repeat (40) @(posedge clk);
        #1 chk("off oe", 8'h00, {7'h00, sck_oe});
        rc("off st", a_st, 8'h00);
    endtask : t_off

    task automatic t_slave;
        logic [7:0] s;
        wr(a_ct, 8'h43);
        wr(a_dt, 8'h96);
        ss_n <= 1'b0;
        sbyte(8'h3b, 16, s);
        chk("slave out", 8'h96, s);
        chk("miso oe", 8'h01, {7'h00, miso_oe});
        sbyte(8'hff, 6, s);
        ss_n <= 1'b1;
        repeat (3) @(posedge clk);
        ss_n <= 1'b0;
        sbyte(8'hc4, 16, s);
        // Last SCK change is only seen one clock later
        repeat (2) @(posedge clk);
        ss_n <= 1'b1;
        repeat (3) @(posedge clk);
        rc("slave st", a_st, 8'h80);
        rc("slave rx", a_dt, 8'hc4);
    endtask : t_slave

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs;
        t_master;
        t_buf;
        t_coll;
        t_fault;
        t_off;
        t_slave;
        end_sim;
    end
endmodule : tb_top
